// ### hdl/jtx_pkg.sv
// Constants for the transmit link sequencer
package jtx_pkg;
  localparam logic [7:0] K_COMMA    = 8'hBC;
  localparam logic [7:0] R_START    = 8'h1C;
  localparam logic [7:0] Q_CONFIG   = 8'h9C;
  localparam logic [7:0] A_ALIGN    = 8'h7C;
  localparam int         OCTETS     = 4;
  localparam int         WORD_W     = 32;
  localparam int         CFG_OCTETS = 14;
  localparam int         ILAS_MF    = 4;
  localparam int         K_EXTRA_OCTETS = 9;
  localparam int         F_DEF      = 4;
  localparam int         K_DEF      = 16;
  localparam int         LANES_DEF  = 2;
  localparam logic [7:0] SEED_DEF   = 8'h00;
  typedef enum logic [1:0] {JTX_ST_CGS, JTX_ST_KTAIL, JTX_ST_ILAS, JTX_ST_DATA} jtx_state_t;
endpackage : jtx_pkg

// ### hdl/jtx_lane_word.sv
// One lane's octet multiplexer with per-octet control flags
module jtx_lane_word
  import jtx_pkg::*;
(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // Selection
  input  wire jtx_state_t        state,
  input  wire logic [4*8-1:0]    ilas_octets,
  input  wire logic [3:0]        ilas_ctrl,
  input  wire logic [31:0]       user_word,
  // Lane output
  output logic [31:0]            word_ff,
  output logic [3:0]             ctrl_ff
);
  wire logic [31:0] nxt_word;
  wire logic [3:0]  nxt_ctrl;
  wire logic        send_k;

  assign send_k   = (state == JTX_ST_CGS) || (state == JTX_ST_KTAIL);
  assign nxt_word = send_k ? {OCTETS{K_COMMA}} :
                    (state == JTX_ST_ILAS) ? ilas_octets : user_word;
  assign nxt_ctrl = send_k ? 4'hF :
                    (state == JTX_ST_ILAS) ? ilas_ctrl : 4'h0;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      word_ff <= {OCTETS{K_COMMA}};
      ctrl_ff <= 4'hF;
    end else begin
      word_ff <= nxt_word;
      ctrl_ff <= nxt_ctrl;
    end
  end
endmodule : jtx_lane_word

// ### hdl/jtx_link_seq.sv
// Transmit link sequencer: comma sync, lane alignment, then user data
//
// Behaviour
// - Sync request answered with commas on all lanes
// - Every octet is K28.5 during sync request
// - Each lane word is 32 bits, four octets
// - Control flag set for control characters only
// - Commas continue one frame plus nine octets, rounded up to whole four-octet words
// - R character starts each alignment multiframe
// - A character ends each alignment multiframe
// - Error output asserts only on link error
// - Q follows R in second multiframe
// - Second multiframe carries fourteen config octets
// - User data right after fourth multiframe
module jtx_link_seq
  import jtx_pkg::*;
#(
  parameter int LANES = LANES_DEF,
  parameter int F     = F_DEF,
  parameter int K     = K_DEF
) (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  // Receiver sync request, active low
  input  wire logic                 sync_n,
  // Link configuration octets, 14 per lane, octet 0 in low bits
  input  wire logic [LANES*112-1:0] cfg_octets,
  // Transport layer data
  input  wire logic [LANES*32-1:0]  user_data,
  output logic                      user_ready,
  // Lane outputs
  output logic [LANES*32-1:0]       lane_tx_octet_bus,
  output logic [LANES*4-1:0]        lane_ctrl_char_flags,
  // Error indication
  output logic                      tx_link_error_irq
);
  // ==========================================================
  // Octet counting
  localparam int MF_OCT   = F * K;
  localparam int MF_WORDS = MF_OCT / OCTETS;
  localparam int KT_WORDS = (F + K_EXTRA_OCTETS + OCTETS - 1) / OCTETS;
  localparam int ILAS_WORDS = ILAS_MF * MF_WORDS;

  jtx_state_t  state_ff;
  jtx_state_t  nxt_state;
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  logic        err_ff;
  wire logic   ktail_done;
  wire logic   ilas_done;
  wire logic   sync_lost;

  assign ktail_done = (cnt_ff == 16'(KT_WORDS - 1));
  assign ilas_done  = (cnt_ff == 16'(ILAS_WORDS - 1));
  assign sync_lost  = !sync_n && (state_ff == JTX_ST_DATA);

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff + 16'h0001;
    case (state_ff)
      JTX_ST_CGS: begin
        nxt_cnt = 16'h0000;
        if (sync_n) nxt_state = JTX_ST_KTAIL;
      end
      JTX_ST_KTAIL: begin
        if (!sync_n) begin
          nxt_state = JTX_ST_CGS;
          nxt_cnt   = 16'h0000;
        end else if (ktail_done) begin
          nxt_state = JTX_ST_ILAS;
          nxt_cnt   = 16'h0000;
        end
      end
      JTX_ST_ILAS: begin
        if (!sync_n) begin
          nxt_state = JTX_ST_CGS;
          nxt_cnt   = 16'h0000;
        end else if (ilas_done) begin
          nxt_state = JTX_ST_DATA;
          nxt_cnt   = 16'h0000;
        end
      end
      JTX_ST_DATA: begin
        nxt_cnt = 16'h0000;
        if (!sync_n) nxt_state = JTX_ST_CGS;
      end
      default: begin
        nxt_state = JTX_ST_CGS;
        nxt_cnt   = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_ff <= JTX_ST_CGS;
      cnt_ff   <= 16'h0000;
      err_ff   <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      err_ff   <= err_ff | sync_lost;
    end
  end

  assign tx_link_error_irq = err_ff;
  assign user_ready        = (state_ff == JTX_ST_DATA) && sync_n;

  // ==========================================================
  // Alignment sequence octet positions
  wire logic [15:0] word_in_mf;
  wire logic [15:0] mf_idx;
  wire logic        mf_first;
  wire logic        mf_last;
  wire logic        cfg_mf;

  assign word_in_mf = cnt_ff % 16'(MF_WORDS);
  assign mf_idx     = cnt_ff / 16'(MF_WORDS);
  assign mf_first   = (word_in_mf == 16'h0000);
  assign mf_last    = (word_in_mf == 16'(MF_WORDS - 1));
  assign cfg_mf     = (mf_idx == 16'h0001);

  // ==========================================================
  // Per-lane word build
  genvar gl;
  genvar go;
  generate
    for (gl = 0; gl < LANES; gl++) begin : g_lane
      wire logic [31:0] ilas_w;
      wire logic [3:0]  ilas_k;
      for (go = 0; go < OCTETS; go++) begin : g_oct
        wire logic [15:0] pos;
        wire logic [15:0] cfg_i;
        wire logic        is_r;
        wire logic        is_q;
        wire logic        is_a;
        wire logic        is_cfg;
        assign pos    = 16'(word_in_mf * 16'(OCTETS) + 16'(go));
        assign is_r   = mf_first && (go == 0);
        assign is_q   = cfg_mf && mf_first && (go == 1);
        assign is_a   = mf_last && (go == OCTETS - 1);
        assign cfg_i  = pos - 16'h0002;
        assign is_cfg = cfg_mf && (pos >= 16'h0002)
                        && (pos < 16'(CFG_OCTETS + 2));
        assign ilas_w[go*8 +: 8] = is_r ? R_START :
                                   is_q ? Q_CONFIG :
                                   is_a ? A_ALIGN :
                                   is_cfg ? cfg_octets[gl*112 + cfg_i[3:0]*8 +: 8] :
                                   8'(pos);
        assign ilas_k[go] = is_r || is_q || is_a;
      end
      jtx_lane_word u_word (
        .ref_clk     (ref_clk),
        .rst         (rst),
        .state       (state_ff),
        .ilas_octets (ilas_w),
        .ilas_ctrl   (ilas_k),
        .user_word   (user_data[gl*32 +: 32]),
        .word_ff     (lane_tx_octet_bus[gl*32 +: 32]),
        .ctrl_ff     (lane_ctrl_char_flags[gl*4 +: 4])
      );
    end
  endgenerate

  // ==========================================================
  // Comma tail length check
  logic [15:0]      k_run_ff;
  wire logic [15:0] nxt_k_run;
  wire logic        lane0_k;

  assign lane0_k   = (lane_tx_octet_bus[31:0] == {OCTETS{K_COMMA}});
  assign nxt_k_run = !sync_n ? 16'h0000 :
                     (lane0_k && (k_run_ff != 16'hFFFF)) ? k_run_ff + 16'h0001 : k_run_ff;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      k_run_ff <= 16'h0000;
    end else begin
      k_run_ff <= nxt_k_run;
    end
  end

  // ==========================================================
  // Checks
  a_cgs_commas: assert property (@(posedge ref_clk) disable iff (rst)
    (state_ff == JTX_ST_CGS) |=> (lane_tx_octet_bus[31:0] == {4{K_COMMA}})
      && (lane_ctrl_char_flags[3:0] == 4'hF))
    else $error("comma not sent during sync request");
  a_sync_to_cgs: assert property (@(posedge ref_clk) disable iff (rst)
    !sync_n |=> (state_ff == JTX_ST_CGS))
    else $error("sync request not answered");
  a_ktail_len: assert property (@(posedge ref_clk) disable iff (rst)
    (sync_n && $past(lane0_k) && (lane_tx_octet_bus[7:0] == R_START)
      && lane_ctrl_char_flags[0])
      |-> (k_run_ff * 16'(OCTETS)) >= 16'(F + K_EXTRA_OCTETS))
    else $error("comma tail too short");
  a_ktail_commas: assert property (@(posedge ref_clk) disable iff (rst)
    (state_ff == JTX_ST_KTAIL) |=> (lane_tx_octet_bus[31:0] == {4{K_COMMA}})
      && (lane_ctrl_char_flags[3:0] == 4'hF))
    else $error("comma tail broken");
  a_ilas_entry: assert property (@(posedge ref_clk) disable iff (rst)
    (state_ff == JTX_ST_ILAS && $past(state_ff) == JTX_ST_KTAIL)
      |-> $past(cnt_ff) == 16'(KT_WORDS - 1))
    else $error("alignment started early");
  a_r_start: assert property (@(posedge ref_clk) disable iff (rst)
    (state_ff == JTX_ST_ILAS && mf_first)
      |=> lane_tx_octet_bus[7:0] == R_START && lane_ctrl_char_flags[0])
    else $error("missing R at multiframe start");
  a_a_end: assert property (@(posedge ref_clk) disable iff (rst)
    (state_ff == JTX_ST_ILAS && mf_last)
      |=> lane_tx_octet_bus[31:24] == A_ALIGN && lane_ctrl_char_flags[3])
    else $error("missing A at multiframe end");
  a_q_second: assert property (@(posedge ref_clk) disable iff (rst)
    (state_ff == JTX_ST_ILAS && cfg_mf && mf_first)
      |=> lane_tx_octet_bus[15:8] == Q_CONFIG)
    else $error("missing Q in second multiframe");
  a_data_follows: assert property (@(posedge ref_clk) disable iff (rst)
    (state_ff == JTX_ST_ILAS && ilas_done && sync_n)
      |=> state_ff == JTX_ST_DATA ##1 lane_ctrl_char_flags[3:0] == 4'h0)
    else $error("user data not immediate");
  a_err_quiet: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(tx_link_error_irq) |-> ($past(state_ff) == JTX_ST_DATA) && !$past(sync_n))
    else $error("error output without cause");
  a_err_raise: assert property (@(posedge ref_clk) disable iff (rst)
    (state_ff == JTX_ST_DATA && !sync_n) |=> tx_link_error_irq)
    else $error("lost sync not reported");
endmodule : jtx_link_seq

// ### verif/jtx_rx_model.sv
// Receiver model driving the active-low sync request
module jtx_rx_model
  import jtx_pkg::*;
#(
  parameter int LANES = LANES_DEF
) (
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst,
  // Bench control
  input  wire logic                hold_req,
  // Lane inputs
  input  wire logic [LANES*32-1:0] lane_tx_octet_bus,
  input  wire logic [LANES*4-1:0]  lane_ctrl_char_flags,
  // Sync request and lock error
  output logic                     sync_n,
  output logic                     cgs_err
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================
  // Comma lock
  int  n_k;
  wire all_k = (lane_tx_octet_bus === {LANES*4{K_COMMA}}) && (&lane_ctrl_char_flags);
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      n_k <= 0;
      sync_n <= 1'b0;
      cgs_err <= 1'b0;
    end else if (hold_req) begin
      n_k <= 0;
      sync_n <= #1 1'b0;
    end else if (!sync_n) begin
      n_k <= all_k ? n_k + 1 : 0;
      cgs_err <= #1 cgs_err | !all_k;
      if (n_k >= 3) sync_n <= #1 1'b1;
    end
  end
endmodule : jtx_rx_model

// ### verif/testbench.sv
// Self-checking bench for the transmit link sequencer
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import jtx_pkg::*;
  localparam int LANES = 2;
  localparam int MFW   = F_DEF * K_DEF / 4;
  localparam int KT    = (F_DEF + K_EXTRA_OCTETS + 3) / 4;
  logic                 ref_clk = 1'b0;
  logic                 rst = 1'b1;
  logic                 hold_req = 1'b1;
  logic [LANES*112-1:0] cfg_octets = '0;
  logic [LANES*32-1:0]  user_data = '0;
  logic [LANES*32-1:0]  lane_tx_octet_bus;
  logic [LANES*4-1:0]   lane_ctrl_char_flags;
  logic                 sync_n, user_ready, tx_link_error_irq, cgs_err;
  logic [31:0]          rs = 32'h53CB3058;
  logic [63:0]          q[$];
  int                   n_mismatch = 0;
  int                   checks_done = 0;
  int                   n;
  jtx_link_seq #(.LANES(LANES), .F(F_DEF), .K(K_DEF)) i_dut (.ref_clk(ref_clk), .rst(rst),
    .sync_n(sync_n), .cfg_octets(cfg_octets), .user_data(user_data), .user_ready(user_ready),
    .lane_tx_octet_bus(lane_tx_octet_bus), .lane_ctrl_char_flags(lane_ctrl_char_flags),
    .tx_link_error_irq(tx_link_error_irq));
  jtx_rx_model #(.LANES(LANES)) i_rx (.ref_clk(ref_clk), .rst(rst), .hold_req(hold_req),
    .lane_tx_octet_bus(lane_tx_octet_bus), .lane_ctrl_char_flags(lane_ctrl_char_flags),
    .sync_n(sync_n), .cgs_err(cgs_err));
  // ==========================
  // Helpers
  function logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : rnd
  task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task finish_test;
    if (n_mismatch == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test
  task timeout;
    n_mismatch++;
    $display("mismatch wait expected event seen none");
    finish_test;
  endtask : timeout
  task tick;
    @(negedge ref_clk);
  endtask : tick
  task automatic chk_k;
    chk("commas", {LANES*4{K_COMMA}}, lane_tx_octet_bus);
    chk("comma flags", {LANES*4{1'b1}}, lane_ctrl_char_flags);
    chk("ready", 0, user_ready);
  endtask : chk_k
  task automatic chk_ilas(int mf, int w);
    logic [31:0] wd, ex;
    chk("irq", 0, tx_link_error_irq);
    for (int l = 0; l < LANES; l++) begin
      wd = lane_tx_octet_bus[l*32+:32];
      ex = {w == MFW-1, 1'b0, mf == 1 && w == 0, w == 0};
      chk("ilas flags", ex, lane_ctrl_char_flags[l*4+:4]);
      if (w == 0) chk("r char", R_START, wd[7:0]);
      if (w == MFW-1) chk("a char", A_ALIGN, wd[31:24]);
      if (mf == 1 && w < 4) begin
        for (int j = 0; j < 4; j++) begin
          if (4*w+j < 2) ex[8*j+:8] = j ? Q_CONFIG : R_START;
          else ex[8*j+:8] = cfg_octets[l*112+8*(4*w+j-2)+:8];
        end
        chk("config", ex, wd);
      end
    end
  endtask : chk_ilas
  // ==========================
  // Stimulus
  initial forever #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) user_data <= #1 {rnd(), rnd()};
  always @(negedge ref_clk) if (user_ready === 1'b1) q.push_back(user_data);
  initial begin
    for (int it = 0; it < 3; it++) begin
      @(posedge ref_clk);
      #1 rst = 1'b1;
      hold_req = 1'b1;
      for (int i = 0; i < LANES*112/32; i++) cfg_octets[32*i+:32] = rnd();
      repeat (5) @(posedge ref_clk);
      #1 rst = 1'b0;
      q.delete();
      repeat (2 + it * 7) tick;
      chk_k;
      chk("irq", 0, tx_link_error_irq);
      if (it > 0) begin
        @(posedge ref_clk);
        #1 hold_req = 1'b0;
        n = 0;
        while (sync_n !== 1'b1) begin tick; if (++n > 200) timeout; end
        repeat (1 + rnd() % 60) tick;
        @(posedge ref_clk);
        #1 hold_req = 1'b1;
        repeat (4) tick;
        chk_k;
        chk("irq", 0, tx_link_error_irq);
      end
      @(posedge ref_clk);
      #1 hold_req = 1'b0;
      n = 0;
      while (sync_n !== 1'b1) begin tick; if (++n > 200) timeout; end
      n = 0;
      tick;
      while (lane_tx_octet_bus === {LANES*4{K_COMMA}}) begin
        n++;
        tick;
        if (n > 50) timeout;
      end
      chk("comma tail", 1, n >= KT);
      for (int mf = 0; mf < ILAS_MF; mf++)
        for (int w = 0; w < MFW; w++) begin chk_ilas(mf, w); tick; end
      repeat (4) begin
        chk("data", q.size() ? q.pop_front() : 'x, lane_tx_octet_bus);
        chk("data flags", 0, lane_ctrl_char_flags);
        chk("ready", 1, user_ready);
        tick;
      end
      @(posedge ref_clk);
      #1 hold_req = 1'b1;
      n = 0;
      while (tx_link_error_irq !== 1'b1) begin tick; if (++n > 6) timeout; end
      repeat (3) tick;
      chk_k;
      chk("lock error", 0, cgs_err);
    end
    finish_test;
  end
endmodule : testbench
